// ### verilog/toc_params.svh
// Constants of the 16-bit timer output compare block: offsets, fields, reset values.
// Assumes a 32-bit classic Wishbone bus with byte addresses on an 8-bit adr_i.
`ifndef TOC_PARAMS_SVH
`define TOC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TOC_OFS_CTRL        8'h00
`define TOC_OFS_FLAGS       8'h04
`define TOC_OFS_COUNT_LOW   8'h08
`define TOC_OFS_COUNT_HIGH  8'h0C
`define TOC_OFS_MATCH_A_LOW 8'h10
`define TOC_OFS_MATCH_A_HI  8'h14
`define TOC_OFS_MATCH_B_LOW 8'h18
`define TOC_OFS_MATCH_B_HI  8'h1C
`define TOC_OFS_CAPT_LOW    8'h20
`define TOC_OFS_CAPT_HIGH   8'h24

// ----------------------------------------------------------------------------
// Field positions in the control and flag registers
// ----------------------------------------------------------------------------
`define TOC_CTRL_WGM_LSB    0
`define TOC_CTRL_CS_LSB     4
`define TOC_CTRL_COM_LSB    8
`define TOC_CTRL_OIE_LSB    12
`define TOC_CTRL_TOVIE_BIT  14
`define TOC_CTRL_PORT_LSB   16
`define TOC_CTRL_DDR_LSB    18
`define TOC_FLAG_OCF_LSB    0
`define TOC_FLAG_TOV_BIT    2
`define TOC_FLAG_FORCE_LSB  8

// ----------------------------------------------------------------------------
// Counter limits and reset values
// ----------------------------------------------------------------------------
`define TOC_MAX             16'hFFFF
`define TOC_BOTTOM          16'h0000
`define TOC_TOP_8BIT        16'h00FF
`define TOC_TOP_9BIT        16'h01FF
`define TOC_TOP_10BIT       16'h03FF
`define TOC_RST_WORD        16'h0000
`define TOC_RST_BYTE        8'h00

`endif

// ### verilog/toc_pkg.sv
// Types of the 16-bit timer output compare block.
// Assumes nothing of its surroundings.
package toc_pkg;

  // --------------------------------------------------------------------------
  // Counting styles selected by the waveform mode
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    TOC_NORMAL = 2'b00,
    TOC_CTC    = 2'b01,
    TOC_FAST   = 2'b10,
    TOC_DUAL   = 2'b11
  } toc_wave_t;

  // --------------------------------------------------------------------------
  // Whole state of the block
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0]       cnt;
    logic [7:0]        temp;
    logic [1:0][15:0]  ocr;
    logic [1:0][15:0]  obuf;
    logic [15:0]       icr;
    logic [3:0]        wgm;
    logic [2:0]        cs;
    logic [1:0][1:0]   com;
    logic [1:0]        oie;
    logic              tov_ie;
    logic [1:0]        port;
    logic [1:0]        ddr;
    logic [1:0]        ocf;
    logic              tov;
    logic [1:0]        oc;
    logic              blk;
    logic              dn;
    logic              ack;
    logic [31:0]       rdat;
  } toc_state_t;

endpackage : toc_pkg

// ### verilog/toc_timer16_output_compare.sv
// Output compare section of a 16-bit timer: counter, two compare channels, flags, pin override.
// Assumes a classic Wishbone master on clk_i and a one-cycle timer tick on count_tick_i.
`timescale 1ns/100ps
`include "toc_params.svh"

// What this block does
// (RULE1) Each channel compares counter to its match value; equality sets flag next tick.
// (RULE2) Set flag with enable requests interrupt; servicing clears the flag.
// (RULE3) Writing one to a flag bit clears that flag.
// (RULE4) Channel A match value may set TOP, fixing resolution and period.
// (RULE5) Match values double buffered in PWM modes, direct in normal and CTC.
// (RULE6) Buffered value loads into active register only at TOP or BOTTOM.
// (RULE7) Match values change only by writes; reads bypass the shared high latch.
// (RULE8) High byte goes to latch; low write moves both bytes at once.
// (RULE9) Force strobe in non-PWM acts like a match, without flag or counter change.
// (RULE10) Counter write blocks all matches for the next timer tick, even stopped.
// (RULE11) Software must not write counter equal to a variable TOP.
// (RULE12) Output state keeps its value across waveform mode changes.
// (RULE13) Output action bits apply at once, from the next match.
// (RULE14) Reset clears each channel output state to zero.
// (RULE15) Nonzero action replaces port value on pin; direction bit still governs.
// (RULE16) Action zero leaves output state unchanged on a match.
// (RULE17) Action bits do not touch capture behaviour.
// (RULE18) Only the waveform mode shapes the counting sequence.
// (RULE19) Non-PWM actions toggle, clear or set; PWM actions choose polarity.
// (RULE20) Mode zero counts up only and wraps from all ones to zero.
// (RULE21) Normal mode sets overflow flag on reaching zero; service or a write of one clears it.
// (RULE22) Clock select zero stops counting; counter stays readable and writable.
// (RULE23) A counter write wins over any count or clear that cycle.
// (RULE24) Writing zero to a flag keeps it; force strobes read as zero.
module toc_timer16_output_compare
  import toc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        count_tick_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [1:0]  match_irq_ack_i,
  input  wire logic        ovf_irq_ack_i,
  output logic      [1:0]  match_irq_o,
  output logic             ovf_irq_o,
  output logic      [1:0]  match_pin_o,
  output logic      [1:0]  match_pin_oe_o
);

  // --------------------------------------------------------------------------
  // State and decoded mode
  // --------------------------------------------------------------------------
  toc_state_t  st_ff;
  toc_state_t  nxt_st;
  toc_wave_t   kind;
  logic [15:0] top;
  logic        var_top;
  logic        load_at_top;
  logic        load_at_bot;
  logic        run;
  logic        at_top;
  logic        wrap_bot;
  logic        buf_load;
  logic        hit;
  logic        wr;
  logic        rd_start;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] ctrl_word;

  // (RULE4) Top selection by mode.
  always_comb begin
    kind        = TOC_NORMAL;
    top         = `TOC_MAX;
    var_top     = 1'b0;
    load_at_top = 1'b0;
    load_at_bot = 1'b0;
    case (st_ff.wgm)
      4'h1, 4'h2, 4'h3: begin
        kind        = TOC_DUAL;
        top         = (st_ff.wgm == 4'h1) ? `TOC_TOP_8BIT : (st_ff.wgm == 4'h2) ? `TOC_TOP_9BIT : `TOC_TOP_10BIT;
        load_at_top = 1'b1;
      end
      4'h4: begin
        kind    = TOC_CTC;
        top     = st_ff.ocr[0];
        var_top = 1'b1;
      end
      4'h5, 4'h6, 4'h7: begin
        kind        = TOC_FAST;
        top         = (st_ff.wgm == 4'h5) ? `TOC_TOP_8BIT : (st_ff.wgm == 4'h6) ? `TOC_TOP_9BIT : `TOC_TOP_10BIT;
        load_at_top = 1'b1;
      end
      4'h8, 4'h9: begin
        kind        = TOC_DUAL;
        top         = (st_ff.wgm == 4'h8) ? st_ff.icr : st_ff.ocr[0];
        var_top     = 1'b1;
        load_at_bot = 1'b1;
      end
      4'hA, 4'hB: begin
        kind        = TOC_DUAL;
        top         = (st_ff.wgm == 4'hA) ? st_ff.icr : st_ff.ocr[0];
        var_top     = 1'b1;
        load_at_top = 1'b1;
      end
      4'hC: begin
        kind    = TOC_CTC;
        top     = st_ff.icr;
        var_top = 1'b1;
      end
      4'hE, 4'hF: begin
        kind        = TOC_FAST;
        top         = (st_ff.wgm == 4'hE) ? st_ff.icr : st_ff.ocr[0];
        var_top     = 1'b1;
        load_at_top = 1'b1;
      end
      default: begin
        kind = TOC_NORMAL;
        top  = `TOC_MAX;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  assign wmask     = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign ctrl_word = {12'h000, st_ff.ddr, st_ff.port, 1'b0, st_ff.tov_ie, st_ff.oie, st_ff.com, 1'b0, st_ff.cs,
                      st_ff.wgm};

  always_comb begin
    nxt_st   = st_ff;
    run      = 1'b0;
    at_top   = 1'b0;
    wrap_bot = 1'b0;
    buf_load = 1'b0;
    hit      = 1'b0;
    wval     = 32'h0000_0000;
    // The write lands on the edge where the master sees ack, never earlier.
    wr       = cyc_i & stb_i & we_i & st_ff.ack;
    rd_start = cyc_i & stb_i & ~st_ff.ack;
    nxt_st.ack = cyc_i & stb_i & ~st_ff.ack;

    // (RULE2) Interrupt service clears flags.
    nxt_st.ocf = st_ff.ocf & ~match_irq_ack_i;
    nxt_st.tov = st_ff.tov & ~ovf_irq_ack_i;

    // (RULE3) Write one to clear; (RULE24) zero keeps the flag.
    if (wr && adr_i == `TOC_OFS_FLAGS && sel_i[0]) begin
      nxt_st.ocf = nxt_st.ocf & ~dat_i[`TOC_FLAG_OCF_LSB +: 2];
      nxt_st.tov = nxt_st.tov & ~dat_i[`TOC_FLAG_TOV_BIT];
    end

    // (RULE22) Clock select zero stops the counter.
    run = count_tick_i & (st_ff.cs != 3'b000);

    if (run) begin
      // (RULE10) The block lasts exactly one timer tick.
      nxt_st.blk = 1'b0;
      // (RULE11) A blocked match on a variable TOP is skipped, so the counter runs on.
      at_top = (st_ff.cnt == top) & ~(st_ff.blk & var_top);

      // (RULE18) Only the waveform mode drives the count sequence.
      case (kind)
        TOC_CTC, TOC_FAST: begin
          if (at_top) begin
            nxt_st.cnt = `TOC_BOTTOM;
            wrap_bot   = (kind == TOC_FAST);
            buf_load   = (kind == TOC_FAST);
            if (kind == TOC_FAST) begin
              nxt_st.tov = 1'b1;
            end
          end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
          end
          if (kind == TOC_CTC && st_ff.cnt == `TOC_MAX) begin
            nxt_st.tov = 1'b1;
          end
        end
        TOC_DUAL: begin
          if (!st_ff.dn) begin
            if (at_top) begin
              nxt_st.dn  = 1'b1;
              nxt_st.cnt = st_ff.cnt - 16'h0001;
              buf_load   = load_at_top;
            end else begin
              nxt_st.cnt = st_ff.cnt + 16'h0001;
            end
          end else if (st_ff.cnt == `TOC_BOTTOM) begin
            nxt_st.dn  = 1'b0;
            nxt_st.cnt = st_ff.cnt + 16'h0001;
            nxt_st.tov = 1'b1;
            buf_load   = load_at_bot;
          end else begin
            nxt_st.cnt = st_ff.cnt - 16'h0001;
          end
        end
        default: begin
          // (RULE20) Plain up count with natural wrap.
          nxt_st.cnt = st_ff.cnt + 16'h0001;
          nxt_st.dn  = 1'b0;
          // (RULE21) Overflow flag set as the counter reaches zero.
          if (st_ff.cnt == `TOC_MAX) begin
            nxt_st.tov = 1'b1;
          end
        end
      endcase

      for (int i = 0; i < 2; i++) begin
        // (RULE1) Full 16-bit compare, flag set on this tick.
        hit = (st_ff.cnt == st_ff.ocr[i]) & ~st_ff.blk;
        if (hit) begin
          nxt_st.ocf[i] = 1'b1;
          // (RULE13) Action bits read live; (RULE16) zero does nothing.
          // (RULE19) Set, clear, toggle or polarity by style.
          case (kind)
            TOC_FAST: begin
              if (st_ff.com[i][1]) begin
                nxt_st.oc[i] = st_ff.com[i][0];
              end
            end
            TOC_DUAL: begin
              if (st_ff.com[i][1]) begin
                nxt_st.oc[i] = st_ff.dn ^ st_ff.com[i][0];
              end
            end
            default: begin
              case (st_ff.com[i])
                2'b01: nxt_st.oc[i] = ~st_ff.oc[i];
                2'b10: nxt_st.oc[i] = 1'b0;
                2'b11: nxt_st.oc[i] = 1'b1;
                default: nxt_st.oc[i] = st_ff.oc[i];
              endcase
            end
          endcase
        end
        // Bottom action comes after the match so a value equal to TOP gives a steady level.
        if (wrap_bot && st_ff.com[i][1]) begin
          nxt_st.oc[i] = ~st_ff.com[i][0];
        end
        // (RULE6) Buffer moves to the active register only at TOP or BOTTOM.
        if (buf_load) begin
          nxt_st.ocr[i] = st_ff.obuf[i];
        end
      end
    end

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    if (wr) begin
      wval = dat_i & wmask;
      case (adr_i)
        `TOC_OFS_CTRL: begin
          // (RULE12) Mode changes leave the output states alone.
          wval          = (ctrl_word & ~wmask) | wval;
          nxt_st.wgm    = wval[`TOC_CTRL_WGM_LSB +: 4];
          nxt_st.cs     = wval[`TOC_CTRL_CS_LSB +: 3];
          nxt_st.com    = wval[`TOC_CTRL_COM_LSB +: 4];
          nxt_st.oie    = wval[`TOC_CTRL_OIE_LSB +: 2];
          nxt_st.tov_ie = wval[`TOC_CTRL_TOVIE_BIT];
          nxt_st.port   = wval[`TOC_CTRL_PORT_LSB +: 2];
          nxt_st.ddr    = wval[`TOC_CTRL_DDR_LSB +: 2];
        end
        `TOC_OFS_FLAGS: begin
          if (sel_i[1]) begin
            for (int i = 0; i < 2; i++) begin
              // (RULE9) Forced match: output only, no flag, no counter change.
              if (dat_i[`TOC_FLAG_FORCE_LSB + i] && (kind == TOC_NORMAL || kind == TOC_CTC)) begin
                case (st_ff.com[i])
                  2'b01: nxt_st.oc[i] = ~st_ff.oc[i];
                  2'b10: nxt_st.oc[i] = 1'b0;
                  2'b11: nxt_st.oc[i] = 1'b1;
                  default: nxt_st.oc[i] = st_ff.oc[i];
                endcase
              end
            end
          end
        end
        `TOC_OFS_COUNT_HIGH, `TOC_OFS_MATCH_A_HI, `TOC_OFS_MATCH_B_HI, `TOC_OFS_CAPT_HIGH: begin
          // (RULE8) High byte parks in the shared latch.
          if (sel_i[0]) begin
            nxt_st.temp = dat_i[7:0];
          end
        end
        `TOC_OFS_COUNT_LOW: begin
          if (sel_i[0]) begin
            // (RULE23) Counter write overrides the step above.
            nxt_st.cnt = {st_ff.temp, dat_i[7:0]};
            // (RULE10) Suppress matches on the next tick.
            nxt_st.blk = 1'b1;
          end
        end
        `TOC_OFS_MATCH_A_LOW, `TOC_OFS_MATCH_B_LOW: begin
          if (sel_i[0]) begin
            // (RULE8) Both bytes move together; (RULE5) direct when not PWM.
            nxt_st.obuf[adr_i[3]] = {st_ff.temp, dat_i[7:0]};
            if (kind == TOC_NORMAL || kind == TOC_CTC) begin
              nxt_st.ocr[adr_i[3]] = {st_ff.temp, dat_i[7:0]};
            end
          end
        end
        `TOC_OFS_CAPT_LOW: begin
          if (sel_i[0]) begin
            nxt_st.icr = {st_ff.temp, dat_i[7:0]};
          end
        end
        default: begin
          nxt_st.temp = st_ff.temp;
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // Register reads, captured in the cycle before ack
    // ------------------------------------------------------------------------
    if (rd_start) begin
      nxt_st.rdat = 32'h0000_0000;
      if (!we_i) begin
        case (adr_i)
          `TOC_OFS_CTRL:  nxt_st.rdat = ctrl_word;
          // (RULE24) Force strobes read as zero.
          `TOC_OFS_FLAGS: nxt_st.rdat = {29'h0000_0000, st_ff.tov, st_ff.ocf};
          `TOC_OFS_COUNT_LOW: begin
            nxt_st.rdat = {24'h00_0000, st_ff.cnt[7:0]};
            nxt_st.temp = st_ff.cnt[15:8];
          end
          `TOC_OFS_CAPT_LOW: begin
            nxt_st.rdat = {24'h00_0000, st_ff.icr[7:0]};
            nxt_st.temp = st_ff.icr[15:8];
          end
          `TOC_OFS_COUNT_HIGH, `TOC_OFS_CAPT_HIGH: nxt_st.rdat = {24'h00_0000, st_ff.temp};
          // (RULE7) Match values read straight, not through the latch.
          `TOC_OFS_MATCH_A_LOW: nxt_st.rdat = {24'h00_0000, st_ff.obuf[0][7:0]};
          `TOC_OFS_MATCH_A_HI:  nxt_st.rdat = {24'h00_0000, st_ff.obuf[0][15:8]};
          `TOC_OFS_MATCH_B_LOW: nxt_st.rdat = {24'h00_0000, st_ff.obuf[1][7:0]};
          `TOC_OFS_MATCH_B_HI:  nxt_st.rdat = {24'h00_0000, st_ff.obuf[1][15:8]};
          default: nxt_st.rdat = 32'h0000_0000;
        endcase
      end
    end

    // (RULE2) Hardware sets win over a same-cycle clear.
    nxt_st.ocf = nxt_st.ocf;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      // (RULE14) Output states start at zero.
      st_ff.oc <= 2'b00;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign dat_o       = st_ff.rdat;
  assign ack_o       = st_ff.ack;
  // (RULE2) Request while flag and enable are both set.
  assign match_irq_o = st_ff.ocf & st_ff.oie;
  assign ovf_irq_o   = st_ff.tov & st_ff.tov_ie;

  // (RULE15) Nonzero action takes the pin; direction bit keeps the enable.
  // (RULE17) Action bits feed nothing but the pin and output state.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      match_pin_o[i] = (st_ff.com[i] != 2'b00) ? st_ff.oc[i] : st_ff.port[i];
    end
  end
  assign match_pin_oe_o = st_ff.ddr;

endmodule // toc_timer16_output_compare

// ### testbench/toc_monitor.sv
// Concurrent checks on the ports of the timer output compare block.
// Assumes one clock, synchronous active-high reset and a classic Wishbone master.
`timescale 1ns/100ps
module toc_monitor
  import toc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        count_tick_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [1:0]  match_irq_ack_i,
  input wire logic        ovf_irq_ack_i,
  input wire logic [1:0]  match_irq_o,
  input wire logic        ovf_irq_o,
  input wire logic [1:0]  match_pin_o,
  input wire logic [1:0]  match_pin_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------------------
  // Bus and outputs
  // ---------------------------------------------------------------------------
  ack_after_req_a: assert property (ce_i && cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged in the next cycle");
  ack_single_a: assert property (ce_i && ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  ack_has_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("acknowledge without a request");
  flag_ack_clears_a: assert property (ce_i && match_irq_ack_i[0] && !count_tick_i |=> !match_irq_o[0])
    else $error("serviced match request still high");
  ovf_ack_clears_a: assert property (ce_i && ovf_irq_ack_i && !count_tick_i |=> !ovf_irq_o)
    else $error("serviced overflow request still high");
  irq_rise_cause_a: assert property ($rose(match_irq_o[0]) |-> $past(count_tick_i || (ack_o && we_i)))
    else $error("match request rose without tick or write");
  ovf_rise_cause_a: assert property ($rose(ovf_irq_o) |-> $past(count_tick_i || (ack_o && we_i)))
    else $error("overflow request rose without tick or write");
  oe_by_write_a: assert property ($changed(match_pin_oe_o) |-> $past((ack_o && we_i) || rst_i))
    else $error("pin enable changed without a write");
  pin_change_cause_a: assert property ($changed(match_pin_o) |-> $past(count_tick_i || (ack_o && we_i) || rst_i))
    else $error("pin changed without tick or write");
  dat_hold_a: assert property ($changed(dat_o) |-> $past((cyc_i && stb_i) || rst_i))
    else $error("read data changed without a request");
  reset_state_a: assert property (@(posedge clk_i) disable iff (!ce_i) rst_i |=>
    (match_pin_o == 2'h0) && (match_pin_oe_o == 2'h0) && !ack_o && (match_irq_o == 2'h0) && !ovf_irq_o)
    else $error("outputs not cleared by reset");
endmodule // toc_monitor

bind toc_timer16_output_compare toc_monitor u_toc_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .count_tick_i(count_tick_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .match_irq_ack_i(match_irq_ack_i), .ovf_irq_ack_i(ovf_irq_ack_i), .match_irq_o(match_irq_o),
  .ovf_irq_o(ovf_irq_o), .match_pin_o(match_pin_o), .match_pin_oe_o(match_pin_oe_o));

// ### testbench/testbench.sv
// Self-checking bench for the timer output compare block.
// Assumes the block answers every bus request and counts on single-cycle tick pulses.
`timescale 1ns/100ps
`include "toc_params.svh"
module testbench;
  import toc_pkg::*;
  logic        clk_i           = 1'h0;
  logic        rst_i           = 1'h1;
  logic        ce_i            = 1'h1;
  logic        count_tick_i    = 1'h0;
  logic        cyc_i           = 1'h0;
  logic        stb_i           = 1'h0;
  logic        we_i            = 1'h0;
  logic [7:0]  adr_i           = 8'h00;
  logic [3:0]  sel_i           = 4'h0;
  logic [31:0] dat_i           = 32'h0;
  logic [1:0]  match_irq_ack_i = 2'h0;
  logic        ovf_irq_ack_i   = 1'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [1:0]  match_irq_o;
  logic        ovf_irq_o;
  logic [1:0]  match_pin_o;
  logic [1:0]  match_pin_oe_o;
  logic [31:0] rdat;
  int          err_count       = 0;
  int          comparisons     = 0;
  logic [1:0]  com_tab [4]     = '{2'h2, 2'h3, 2'h0, 2'h1};
  logic        pin_tab [4]     = '{1'h0, 1'h1, 1'h0, 1'h0};

  toc_timer16_output_compare u_toc_timer16_output_compare (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .count_tick_i(count_tick_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .match_irq_ack_i(match_irq_ack_i), .ovf_irq_ack_i(ovf_irq_ack_i), .match_irq_o(match_irq_o),
    .ovf_irq_o(ovf_irq_o), .match_pin_o(match_pin_o), .match_pin_oe_o(match_pin_oe_o));

  always #50 clk_i = ~clk_i;

  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The request is held until ack is sampled high; a lost ack counts as a mismatch.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && n < 20);
    if (n >= 20) check(32'h0, 32'h1);
    rdat = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    check(rdat, exp);
  endtask

  // High byte goes first into the shared latch; the low write moves both.
  task automatic w16(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] v);
    wr(hi, {24'h0, v[15:8]});
    wr(lo, {24'h0, v[7:0]});
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      count_tick_i <= 1'h1;
      @(posedge clk_i);
      count_tick_i <= 1'h0;
    end
  endtask

  task automatic irq_ack(input logic [2:0] v);
    @(posedge clk_i);
    {ovf_irq_ack_i, match_irq_ack_i} <= v;
    @(posedge clk_i);
    {ovf_irq_ack_i, match_irq_ack_i} <= 3'h0;
  endtask

  // Expected value packs overflow request, match requests, pins and pin enables.
  task automatic obs(input logic [6:0] exp);
    @(negedge clk_i);
    check({25'h0, ovf_irq_o, match_irq_o, match_pin_o, match_pin_oe_o}, {25'h0, exp});
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(`TOC_OFS_CTRL, 32'h0);
    obs(7'h00);
    rd(8'h30, 32'h0);
    $display("Test reset done");
    wr(`TOC_OFS_CTRL, 32'h00041110);
    w16(`TOC_OFS_MATCH_A_HI, `TOC_OFS_MATCH_A_LOW, 16'h0105);
    rd(`TOC_OFS_MATCH_A_LOW, 32'h05);
    rd(`TOC_OFS_MATCH_A_HI, 32'h01);
    w16(`TOC_OFS_COUNT_HIGH, `TOC_OFS_COUNT_LOW, 16'h0103);
    tick(2);
    obs(7'h01);
    tick(1);
    obs(7'h15);
    wr(`TOC_OFS_FLAGS, 32'h0);
    rd(`TOC_OFS_FLAGS, 32'h1);
    wr(`TOC_OFS_FLAGS, 32'h1);
    obs(7'h05);
    $display("Test compare done");
    w16(`TOC_OFS_COUNT_HIGH, `TOC_OFS_COUNT_LOW, 16'h0105);
    tick(1);
    obs(7'h05);
    rd(`TOC_OFS_COUNT_LOW, 32'h06);
    rd(`TOC_OFS_COUNT_HIGH, 32'h01);
    wr(`TOC_OFS_FLAGS, 32'h100);
    obs(7'h01);
    w16(`TOC_OFS_COUNT_HIGH, `TOC_OFS_COUNT_LOW, 16'h0104);
    tick(2);
    obs(7'h15);
    irq_ack(3'h1);
    obs(7'h05);
    $display("Test block force done");
    for (int i = 0; i < 4; i++) begin
      wr(`TOC_OFS_CTRL, 32'h00040010 | ({30'h0, com_tab[i]} << `TOC_CTRL_COM_LSB));
      w16(`TOC_OFS_COUNT_HIGH, `TOC_OFS_COUNT_LOW, 16'h0104);
      tick(2);
      obs({3'h0, 1'h0, pin_tab[i], 2'h1});
    end
    wr(`TOC_OFS_FLAGS, 32'h100);
    wr(`TOC_OFS_CTRL, 32'h00040114);
    obs(7'h05);
    $display("Test actions done");
    wr(`TOC_OFS_CTRL, 32'h00044010);
    w16(`TOC_OFS_COUNT_HIGH, `TOC_OFS_COUNT_LOW, 16'hFFFF);
    tick(1);
    obs(7'h41);
    rd(`TOC_OFS_COUNT_LOW, 32'h0);
    wr(`TOC_OFS_CTRL, 32'h00044000);
    tick(3);
    rd(`TOC_OFS_COUNT_LOW, 32'h0);
    irq_ack(3'h4);
    obs(7'h01);
    $display("Test overflow done");
    // Top follows the buffered match A value only once the counter passes the old top.
    wr(`TOC_OFS_CTRL, 32'h0000001F);
    w16(`TOC_OFS_MATCH_A_HI, `TOC_OFS_MATCH_A_LOW, 16'h0003);
    rd(`TOC_OFS_MATCH_A_LOW, 32'h03);
    w16(`TOC_OFS_COUNT_HIGH, `TOC_OFS_COUNT_LOW, 16'h0104);
    tick(6);
    rd(`TOC_OFS_COUNT_LOW, 32'h0);
    // Ticks while the clock enable is low must leave the counter frozen.
    @(posedge clk_i);
    ce_i <= 1'h0;
    tick(2);
    ce_i <= 1'h1;
    rd(`TOC_OFS_COUNT_LOW, 32'h0);
    $display("Test buffer done");
    print_verdict();
  end

  // A run needs well under a thousand cycles; a hang ends here.
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
endmodule // testbench
